// ---- include/mdc_pkg.sv ----
// shared constants, types and layouts of the multiplex data channel
package mdc_pkg;
    // ==========================================================
    // sizes and timing
    localparam int N_DEV = 16;
    localparam int DEV_W = 4;
    localparam int CLK_PERIOD_NS = 100;
    localparam int MACHINE_CYCLE_NS = 1000;
    localparam int MC_CLKS = (MACHINE_CYCLE_NS / CLK_PERIOD_NS < 1) ? 1 :
        MACHINE_CYCLE_NS / CLK_PERIOD_NS;
    localparam int SLOT_W = 4;
    localparam int MCNT_W = 3;
    localparam int BUF_DEPTH = 2;
    // ==========================================================
    // executive page addresses of the control words
    localparam logic [15:0] EXEC_BASE = 16'h0040;
    localparam logic [15:0] CW1_OFS = 16'h0000;
    localparam logic [15:0] CW2_OFS = 16'h0001;
    // ==========================================================
    // count control word layout
    localparam int CW_DIR_BIT = 0;
    localparam int CW_BURST_BIT = 1;
    localparam int CW_WORD_BIT = 2;
    localparam int CW_SIDE_BIT = 15;
    localparam int CW_CNT_LSB = 3;
    localparam int CW_CNT_W = 13;
    localparam logic [15:0] WORD_RST = 16'h0000;
    // ==========================================================
    // control states, one flip-flop each except idle, which is all zeros
    typedef enum logic [6:0] {
        ST_IDLE = 7'b0000000,
        ST_A = 7'b0000001,
        ST_B = 7'b0000010,
        ST_C = 7'b0000100,
        ST_D = 7'b0001000,
        ST_E = 7'b0010000,
        ST_F = 7'b0100000,
        ST_X = 7'b1000000
    } mdc_ctl_t;
    // ==========================================================
    // borrowed memory path
    typedef struct packed {
        logic cyc;
        logic wr;
        logic [1:0] be;
        logic [15:0] addr;
        logic [15:0] wdata;
    } mdc_mem_t;
endpackage

// ---- src/mdc_buf.sv ----
// two-entry data buffer with valid and ready on both sides
`timescale 1ns/1ps
module mdc_buf import mdc_pkg::*; #(
    parameter int W = 16,
    parameter int DEPTH = BUF_DEPTH
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
        $error("mdc_buf: DEPTH must be a power of two, at least 2");
    end
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [PW-1:0] wp;
        logic [PW-1:0] rp;
        logic [PW:0] cnt;
    } mdc_buf_state_t;
    mdc_buf_state_t r, n;
    logic do_push;
    logic do_pop;
    // ==========================================================
    // handshakes
    assign in_ready = r.cnt != (PW+1)'(DEPTH);
    assign out_valid = r.cnt != '0;
    assign out_data = r.mem[r.rp];
    assign do_push = in_valid & in_ready;
    assign do_pop = out_valid & out_ready;
    // ==========================================================
    // next state
    always_comb begin
        n = r;
        if (do_push) begin
            n.mem[r.wp] = in_data;
            n.wp = r.wp + PW'(1);
        end
        if (do_pop) begin
            n.rp = r.rp + PW'(1);
        end
        case ({do_push, do_pop})
            2'b10: n.cnt = r.cnt + (PW+1)'(1);
            2'b01: n.cnt = r.cnt - (PW+1)'(1);
            default: n.cnt = r.cnt;
        endcase
    end
    always_ff @(posedge clk) begin
        if (reset) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end
endmodule // mdc_buf

// ---- src/mdc_channel.sv ----
// multiplex data channel: request ranks, control states and transfer path
// Operation
// - idle forced only at instruction end, level transition end, quiescence, or level set request
// - no idle right after a single-cycle instruction
// - with multiply/divide fitted, wait until that instruction completes
// - pending request enters idle before a higher level takes effect
// - quiescent: service buffers; new level waits until service ends
// - quiescent buffer end always interrupts, even if inhibited
// - every request fetches both control words and tries one transfer
// - 16-bit data register from function bus, word or left-to-right byte
// - count register keeps mode bits; down counter on bits 3 to 15
// - each request sets upper rank; copied to lower once per cycle
// - lower rank encoded to 4-bit device number, held while idle
// - any lower bit starts idle request; then only held device matters
// - decode, gate, OR selected request; two flops mark new requests
// - read count word, then address word, counting down if nonzero
// - input: address, data, count; output: data, address, count
// - sequence follows burst, word/byte modes and controller acknowledge
// - seven one-hot states, one machine cycle each except extra and wait, change at cycle end
// - states: count read, address read, address store, data, count store, extra, wait
// - flops mirror data out, data in, idle request; acknowledge flop
// - count word bits: 0 input, 1 burst, 2 word, 15 right side
// - byte output: left byte onto both lanes, right onto right
// - no acknowledge ends the transfer; later requests still count
// - normal mode transfer takes five machine cycles
`timescale 1ns/1ps
module mdc_channel import mdc_pkg::*; #(
    parameter int N_REQ = N_DEV
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // service requests from controllers
    input wire logic [N_REQ-1:0] srq_in,
    // processor status
    input wire logic instr_end,
    input wire logic single_cycle_instr,
    input wire logic md_fitted,
    input wire logic md_busy,
    input wire logic level_transition_end,
    input wire logic quiescent,
    input wire logic level_set_req,
    input wire logic [15:0] fbus_data,
    // processor control
    output logic cpu_idle,
    output logic level_hold,
    output mdc_mem_t mem_out,
    // parallel io bus
    input wire logic bus_acknowledge_line_n,
    input wire logic [15:0] io_in_data,
    output logic bus_data_out_line_n,
    output logic bus_data_in_line_n,
    output logic bus_idle_request_line_n,
    output logic [15:0] io_out_data,
    output logic io_out_valid,
    input wire logic io_out_ready,
    // status
    output logic [DEV_W-1:0] dev_num,
    output logic end_of_record_request,
    output logic eor_force_int
);
    if (N_REQ < 2 || N_REQ > (1 << DEV_W)) begin : g_bad_nreq
        $error("mdc_channel: N_REQ must lie between 2 and 16");
    end
    typedef struct packed {
        mdc_ctl_t st;
        logic [SLOT_W-1:0] slot;
        logic [N_REQ-1:0] srq_s1;
        logic [N_REQ-1:0] srq_s2;
        logic [N_REQ-1:0] srq_s3;
        logic [N_REQ-1:0] req_lvl;
        logic [N_REQ-1:0] upper;
        logic [N_REQ-1:0] lower;
        logic ack_s1;
        logic ack_s2;
        logic ack_s3;
        logic ack_lvl;
        logic [DEV_W-1:0] dev;
        logic sel_sync;
        logic sel_hold;
        logic [15:0] cw_b;
        logic [15:0] w_reg;
        logic [15:0] c_reg;
        logic data_out;
        logic data_in;
        logic ack;
        logic idle_req;
        logic f_done;
        logic eor;
        logic eor_force;
        logic [MCNT_W-1:0] mc_cnt;
        logic saw_f;
        mdc_mem_t mem;
    } mdc_state_t;
    mdc_state_t r, n;
    logic mc_end;
    logic any_request_pending;
    logic selected_request;
    logic synced_selected_request;
    logic permit;
    logic dir_in;
    logic burst;
    logic word_mode;
    logic side_right;
    logic [CW_CNT_W-1:0] cnt;
    logic buf_in_valid;
    logic buf_in_ready;
    logic [15:0] buf_in_data;
    // ==========================================================
    // helpers
    function automatic logic [N_REQ-1:0] dev_decode(input logic [DEV_W-1:0] d);
        for (int i = 0; i < N_REQ; i++) begin
            dev_decode[i] = (d == DEV_W'(i));
        end
    endfunction
    function automatic logic [DEV_W-1:0] prio_enc(input logic [N_REQ-1:0] v);
        prio_enc = '0;
        for (int i = N_REQ - 1; i >= 0; i--) begin
            if (v[i]) begin
                prio_enc = DEV_W'(i);
            end
        end
    endfunction
    function automatic logic [15:0] cw_addr(input logic [DEV_W-1:0] d,
        input logic [15:0] ofs);
        cw_addr = EXEC_BASE + {11'h000, d, 1'b0} + ofs;
    endfunction
    function automatic logic [15:0] lane_steer(input logic [15:0] c,
        input logic wrd, input logic rgt);
        if (wrd) begin
            lane_steer = c;
        end else if (rgt) begin
            lane_steer = {8'h00, c[7:0]};
        end else begin
            lane_steer = {c[15:8], c[15:8]};
        end
    endfunction
    // ==========================================================
    // decoded signals
    assign mc_end = r.slot == SLOT_W'(MC_CLKS - 1);
    assign any_request_pending = |r.lower;
    assign selected_request = |(dev_decode(r.dev) & r.req_lvl);
    assign synced_selected_request = r.sel_sync & ~r.sel_hold;
    assign permit = (instr_end & ~single_cycle_instr & ~(md_fitted & md_busy))
        | level_transition_end | quiescent;
    assign dir_in = r.cw_b[CW_DIR_BIT];
    assign burst = r.cw_b[CW_BURST_BIT];
    assign word_mode = r.cw_b[CW_WORD_BIT];
    assign side_right = r.cw_b[CW_SIDE_BIT];
    assign cnt = r.cw_b[CW_CNT_LSB +: CW_CNT_W];
    assign buf_in_data = lane_steer((r.st == ST_D) ? fbus_data : r.c_reg,
        word_mode, side_right);
    // ==========================================================
    // next state
    always_comb begin
        n = r;
        buf_in_valid = 1'b0;
        n.eor = 1'b0;
        n.slot = mc_end ? '0 : r.slot + SLOT_W'(1);
        n.srq_s1 = srq_in;
        n.srq_s2 = r.srq_s1;
        n.srq_s3 = r.srq_s2;
        n.req_lvl = (r.srq_s2 & r.srq_s3) | (r.req_lvl & (r.srq_s2 | r.srq_s3));
        n.ack_s1 = ~bus_acknowledge_line_n;
        n.ack_s2 = r.ack_s1;
        n.ack_s3 = r.ack_s2;
        n.ack_lvl = (r.ack_s2 & r.ack_s3) | (r.ack_lvl & (r.ack_s2 | r.ack_s3));
        n.ack = r.ack | r.ack_lvl;
        n.upper = r.upper | r.req_lvl;
        if (mc_end) begin
            n.lower = r.upper;
            n.upper = r.req_lvl;
            n.sel_sync = selected_request;
            n.sel_hold = r.sel_hold & r.sel_sync;
            n.mem = '0;
            n.mc_cnt = r.mc_cnt + MCNT_W'(r.st != ST_IDLE);
        end
        case (r.st)
            ST_IDLE: begin
                if (!r.idle_req && any_request_pending && (permit || level_set_req)) begin
                    n.idle_req = 1'b1;
                    n.dev = prio_enc(r.lower);
                end
                if (r.idle_req && mc_end) begin
                    n.st = ST_A;
                end
            end
            ST_A: begin
                if (mc_end) begin
                    n.cw_b = fbus_data;
                    n.st = ST_B;
                end
            end
            ST_B: begin
                if (mc_end) begin
                    n.w_reg = fbus_data;
                    if (cnt != '0) begin
                        n.cw_b[CW_CNT_LSB +: CW_CNT_W] = cnt - CW_CNT_W'(1);
                    end
                    n.data_in = dir_in;
                    n.st = dir_in ? ST_C : ST_D;
                end
            end
            ST_C: begin
                if (mc_end) begin
                    n.c_reg = dir_in ? io_in_data : r.c_reg;
                    n.st = dir_in ? ST_D : ST_E;
                end
            end
            ST_D: begin
                if (mc_end) begin
                    n.data_in = 1'b0;
                    n.data_out = 1'b0;
                    if (dir_in) begin
                        n.st = ST_E;
                    end else begin
                        n.c_reg = fbus_data;
                        buf_in_valid = 1'b1;
                        n.st = buf_in_ready ? ST_C : ST_F;
                        n.saw_f = ~buf_in_ready;
                    end
                end
            end
            ST_F: begin
                buf_in_valid = ~r.f_done;
                n.f_done = r.f_done | buf_in_ready;
                if (mc_end && (r.f_done || buf_in_ready)) begin
                    n.f_done = 1'b0;
                    n.st = ST_C;
                end
            end
            ST_E: begin
                if (mc_end) begin
                    if (cnt == '0) begin
                        n.eor = 1'b1;
                        n.eor_force = quiescent;
                    end
                    n.st = burst ? ST_X : ST_IDLE;
                    n.idle_req = burst;
                end
            end
            ST_X: begin
                if (mc_end) begin
                    if (synced_selected_request) begin
                        n.st = ST_A;
                    end else if (!r.sel_sync) begin
                        n.st = ST_IDLE;
                        n.idle_req = 1'b0;
                    end
                end
            end
            default: n.st = ST_IDLE;
        endcase
        // entry actions of states A to E
        if (mc_end && n.st == ST_A && r.st != ST_A) begin
            n.ack = 1'b0;
            n.sel_hold = 1'b1;
            n.mc_cnt = '0;
            n.saw_f = 1'b0;
        end
        if (mc_end) begin
            case (n.st)
                ST_A: begin
                    n.mem.cyc = 1'b1;
                    n.mem.addr = cw_addr(n.dev, CW2_OFS);
                end
                ST_B: begin
                    n.mem.cyc = 1'b1;
                    n.mem.addr = cw_addr(r.dev, CW1_OFS);
                end
                ST_C: begin
                    n.w_reg = n.w_reg + 16'h0001;
                    n.mem = '{cyc: 1'b1, wr: 1'b1, be: 2'b11,
                        addr: cw_addr(r.dev, CW1_OFS), wdata: n.w_reg};
                end
                ST_D: begin
                    n.data_out = ~dir_in;
                    n.mem.cyc = ~dir_in | r.ack | r.ack_lvl;
                    n.mem.wr = dir_in;
                    n.mem.addr = n.w_reg;
                    n.mem.be = (word_mode || !dir_in) ? 2'b11 :
                        (side_right ? 2'b01 : 2'b10);
                    n.mem.wdata = word_mode ? n.c_reg :
                        (side_right ? {8'h00, n.c_reg[7:0]} : {n.c_reg[7:0], 8'h00});
                end
                ST_E: begin
                    n.mem = '{cyc: 1'b1, wr: 1'b1, be: 2'b11,
                        addr: cw_addr(r.dev, CW2_OFS), wdata: n.cw_b};
                end
                default: n.mem = '0;
            endcase
        end
    end
    always_ff @(posedge clk) begin
        if (reset) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end
    // ==========================================================
    // output buffer toward the io bus
    mdc_buf #(.W(16), .DEPTH(BUF_DEPTH)) u_buf (
        .clk(clk),
        .reset(reset),
        .in_valid(buf_in_valid),
        .in_ready(buf_in_ready),
        .in_data(buf_in_data),
        .out_valid(io_out_valid),
        .out_ready(io_out_ready),
        .out_data(io_out_data)
    );
    // ==========================================================
    // outputs
    assign cpu_idle = r.idle_req | (r.st != ST_IDLE);
    assign level_hold = cpu_idle;
    assign mem_out = r.mem;
    assign bus_data_out_line_n = ~r.data_out;
    assign bus_data_in_line_n = ~r.data_in;
    assign bus_idle_request_line_n = ~r.idle_req;
    assign dev_num = r.dev;
    assign end_of_record_request = r.eor;
    assign eor_force_int = r.eor & r.eor_force;
    // ==========================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    sequence s_count_store;
        r.st == ST_E && mc_end && cnt == '0;
    endsequence
    sequence s_eor_pulse;
        r.eor ##1 !r.eor;
    endsequence
    AST_IDLE_AT_BOUNDARY: assert property ($rose(r.idle_req) && $past(r.st) == ST_IDLE
        |-> $past(permit || level_set_req))
        else $error("idle request raised outside a boundary");
    AST_NO_IDLE_SINGLE: assert property (r.st == ST_IDLE && !r.idle_req && instr_end
        && single_cycle_instr && !level_transition_end && !quiescent && !level_set_req
        |=> !r.idle_req)
        else $error("idle entered after single-cycle instruction");
    AST_MD_DEFER: assert property (r.st == ST_IDLE && !r.idle_req && md_fitted && md_busy
        && !level_transition_end && !quiescent && !level_set_req |=> !r.idle_req)
        else $error("idle entered during multiply or divide");
    AST_LEVEL_HOLD: assert property (r.st == ST_IDLE && any_request_pending
        && level_set_req |=> level_hold)
        else $error("level not held for pending request");
    AST_UPPER_SET: assert property (!mc_end |=> (r.upper & $past(r.req_lvl))
        == $past(r.req_lvl))
        else $error("request did not set upper rank");
    AST_ONE_HOT: assert property ($onehot0(r.st))
        else $error("control state not one-hot");
    AST_CHANGE_AT_END: assert property (!mc_end |=> $stable(r.st))
        else $error("state changed inside a machine cycle");
    AST_DEV_HELD: assert property (r.st != ST_IDLE |=> $stable(r.dev))
        else $error("device number changed while idle");
    AST_MODE_KEPT: assert property (r.st == ST_B && mc_end
        |=> r.cw_b[2:0] == $past(r.cw_b[2:0]))
        else $error("mode bits disturbed by counter");
    AST_FIVE_CYCLES: assert property (r.st == ST_E && mc_end && !r.saw_f
        |-> r.mc_cnt == 3'h4)
        else $error("normal transfer not five machine cycles");
    AST_EOR: assert property (s_count_store |=> s_eor_pulse)
        else $error("end-of-record request missing");
    AST_NO_ACK_NO_STORE: assert property (r.st == ST_C && mc_end && dir_in
        && !r.ack && !r.ack_lvl |=> !r.mem.cyc)
        else $error("data stored without acknowledge");
endmodule // mdc_channel

// ---- dv/mdc_far_model.sv ----
// memory and device controller model facing the channel
`timescale 1ns/1ps
module mdc_far_model import mdc_pkg::*; (
    // clock
    input wire logic clk,
    // borrowed memory path
    input wire mdc_mem_t mem_out,
    output logic [15:0] fbus_data,
    // controller side
    input wire logic ack_en,
    input wire logic [15:0] dev_word,
    input wire logic bus_data_in_line_n,
    output logic bus_acknowledge_line_n,
    output logic [15:0] io_in_data
);
    // ==========================================================
    // memory and controller answers
    logic [15:0] mem [0:65535];
    initial begin
        fbus_data = 16'h0000;
        bus_acknowledge_line_n = 1'b1;
        io_in_data = 16'hFFFF;
    end
    always @(posedge clk) begin
        if (mem_out.cyc && mem_out.wr && mem_out.be[1]) begin
            mem[mem_out.addr][15:8] <= mem_out.wdata[15:8];
        end
        if (mem_out.cyc && mem_out.wr && mem_out.be[0]) begin
            mem[mem_out.addr][7:0] <= mem_out.wdata[7:0];
        end
        // read data only while a read cycle stands
        if (mem_out.cyc && !mem_out.wr) begin
            fbus_data <= mem[mem_out.addr];
        end else begin
            fbus_data <= ~fbus_data;
        end
        // answer only while asked; withheld to skip the data store
        bus_acknowledge_line_n <= !(ack_en && !bus_data_in_line_n);
        io_in_data <= bus_data_in_line_n ? ~io_in_data : dev_word;
    end
endmodule // mdc_far_model

// ---- dv/mdc_channel_test.sv ----
// self-checking bench of the multiplex data channel
`timescale 1ns/1ps
module mdc_channel_test import mdc_pkg::*; ;
    // ==========================================================
    // signals
    logic clk = 0, reset = 1, instr_end = 0, single_cycle_instr = 0, md_fitted = 0;
    logic md_busy = 0, level_transition_end = 0, quiescent = 0, level_set_req = 0;
    logic io_out_ready = 1, ack_en = 1, cpu_idle, level_hold, bus_acknowledge_line_n;
    logic bus_data_out_line_n, bus_data_in_line_n, bus_idle_request_line_n, io_out_valid;
    logic end_of_record_request, eor_force_int;
    logic [15:0] srq_in = 16'h0000, dev_word = 16'h1234, fbus_data, io_in_data;
    logic [15:0] io_out_data, out_word;
    logic [DEV_W-1:0] dev_num;
    mdc_mem_t mem_out;
    int n_mismatch = 0, samples_checked = 0, n_eor = 0, n_force = 0;
    always #50 clk = ~clk;
    // ==========================================================
    // design and far side
    mdc_channel u_mdc_channel (.clk, .reset, .srq_in, .instr_end, .single_cycle_instr,
        .md_fitted, .md_busy, .level_transition_end, .quiescent, .level_set_req,
        .fbus_data, .cpu_idle, .level_hold, .mem_out, .bus_acknowledge_line_n, .io_in_data,
        .bus_data_out_line_n, .bus_data_in_line_n, .bus_idle_request_line_n, .io_out_data,
        .io_out_valid, .io_out_ready, .dev_num, .end_of_record_request, .eor_force_int);
    mdc_far_model u_mdc_far_model (.clk, .mem_out, .fbus_data, .ack_en, .dev_word,
        .bus_data_in_line_n, .bus_acknowledge_line_n, .io_in_data);
    always @(posedge clk) begin
        if (end_of_record_request === 1'b1) n_eor <= n_eor + 1;
        if (eor_force_int === 1'b1) n_force <= n_force + 1;
        if (io_out_valid === 1'b1 && io_out_ready) out_word <= io_out_data;
    end
    // ==========================================================
    // tasks
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
            n_mismatch++;
        end
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // bounded wait for cpu_idle to reach a level
    task automatic wait_idle(input logic lvl, input int bound);
        int i;
        for (i = 0; i < bound && cpu_idle !== lvl; i++) @(negedge clk);
        if (cpu_idle !== lvl) begin
            $display("MISMATCH cpu_idle expected %b seen %b", lvl, cpu_idle);
            n_mismatch++;
            finish_test();
        end
    endtask
    // raise requests, open a boundary, run one service
    task automatic serve(input logic [15:0] mask, input bit by_level, input logic [3:0] dev);
        srq_in = mask;
        repeat (25) @(negedge clk);
        if (by_level) level_transition_end = 1;
        else instr_end = 1;
        @(negedge clk);
        level_transition_end = 0;
        instr_end = 0;
        wait_idle(1'b1, 5);
        chk("hold idle dev", {10'h000, level_hold, bus_idle_request_line_n, dev_num},
            {10'h000, 2'b10, dev});
        srq_in = 16'h0000;
        wait_idle(1'b0, 200);
        repeat (3) @(negedge clk);
    endtask
    // ==========================================================
    // watchdog
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        finish_test();
    end
    // ==========================================================
    // tests
    initial begin
        int i;
        repeat (8) @(negedge clk);
        reset = 0;
        @(negedge clk);
        chk("reset lines", {11'h000, cpu_idle, bus_idle_request_line_n, bus_data_in_line_n,
            bus_data_out_line_n, io_out_valid}, 16'h000E);
        $display("test reset done");
        // input word, acknowledged
        u_mdc_far_model.mem[16'h0046] = 16'h0100;
        u_mdc_far_model.mem[16'h0047] = 16'h002D;
        serve(16'h0008, 1'b0, 4'h3);
        chk("cw1 dev3", u_mdc_far_model.mem[16'h0046], 16'h0101);
        chk("data dev3", u_mdc_far_model.mem[16'h0101], 16'h1234);
        chk("cw2 dev3", u_mdc_far_model.mem[16'h0047], 16'h0025);
        chk("eor dev3", n_eor[15:0], 16'h0000);
        $display("test input_word done");
        // closed boundaries refused, then acknowledge withheld
        u_mdc_far_model.mem[16'h0048] = 16'h0300;
        u_mdc_far_model.mem[16'h0049] = 16'h002D;
        u_mdc_far_model.mem[16'h0301] = 16'hAAAA;
        ack_en = 0;
        srq_in = 16'h0010;
        repeat (25) @(negedge clk);
        for (i = 0; i < 2; i++) begin
            single_cycle_instr = (i == 0);
            md_fitted = 1;
            md_busy = (i == 1);
            instr_end = 1;
            @(negedge clk);
            instr_end = 0;
            repeat (15) @(negedge clk);
            chk("refused idle", {15'h0000, cpu_idle}, 16'h0000);
        end
        single_cycle_instr = 0;
        md_busy = 0;
        serve(16'h0010, 1'b1, 4'h4);
        chk("cw1 dev4", u_mdc_far_model.mem[16'h0048], 16'h0301);
        chk("data dev4", u_mdc_far_model.mem[16'h0301], 16'hAAAA);
        chk("cw2 dev4", u_mdc_far_model.mem[16'h0049], 16'h0025);
        ack_en = 1;
        $display("test refuse_noack done");
        // output word, last of block, lower device wins
        u_mdc_far_model.mem[16'h0044] = 16'h0200;
        u_mdc_far_model.mem[16'h0045] = 16'h000C;
        u_mdc_far_model.mem[16'h0200] = 16'h5A3C;
        serve(16'h0024, 1'b0, 4'h2);
        chk("out word", out_word, 16'h5A3C);
        chk("cw1 dev2", u_mdc_far_model.mem[16'h0044], 16'h0201);
        chk("cw2 dev2", u_mdc_far_model.mem[16'h0045], 16'h0004);
        chk("eor dev2", n_eor[15:0], 16'h0001);
        $display("test output_word done");
        // burst byte output while quiescent and a level change waits
        u_mdc_far_model.mem[16'h0042] = 16'h0210;
        u_mdc_far_model.mem[16'h0043] = 16'h000A;
        u_mdc_far_model.mem[16'h0210] = 16'hC35A;
        quiescent = 1;
        level_set_req = 1;
        serve(16'h0002, 1'b0, 4'h1);
        quiescent = 0;
        level_set_req = 0;
        chk("out byte", out_word, 16'hC3C3);
        chk("cw1 dev1", u_mdc_far_model.mem[16'h0042], 16'h0211);
        chk("cw2 dev1", u_mdc_far_model.mem[16'h0043], 16'h0002);
        chk("eor force dev1", {n_eor[7:0], n_force[7:0]}, 16'h0201);
        $display("test burst_byte done");
        finish_test();
    end
endmodule // mdc_channel_test
